// *** bench/isa_master.sv ***
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Bus master model of the two-wire link
// ****************************************
module isa_master (
   input  wire logic clk_i,
   input  wire logic scl_i,      // Resolved clock line
   input  wire logic sda_i,      // Resolved data line
   output var  logic scl_lo_o,   // High pulls clock low
   output var  logic sda_lo_o    // High pulls data low
);
   // Lines released at rest, pull-ups give ones
   initial scl_lo_o = 1'b0;
   initial sda_lo_o = 1'b0;

   // One clock: 6 cycles low, 2 high, 160 ns; waits while slave stretches.
   // The long low phase covers the slave's pin sampling delay: it moves
   // SDA some six cycles after it sees a fall.
   task automatic bit_clk(input logic d, output logic q);
      @(posedge clk_i);
      sda_lo_o <= ~d;
      repeat (5) @(posedge clk_i);
      scl_lo_o <= 1'b0;
      // Hold-off while the slave keeps the clock low; the watchdog ends a hang
      do
         @(posedge clk_i);
      while (scl_i !== 1'b1);
      @(posedge clk_i);
      q = sda_i;
      scl_lo_o <= 1'b1;
   endtask : bit_clk

   // Start or repeated start: data falls while clock is high
   task automatic start;
      @(posedge clk_i);
      sda_lo_o <= 1'b0;
      repeat (5) @(posedge clk_i);
      scl_lo_o <= 1'b0;
      repeat (4) @(posedge clk_i);
      sda_lo_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      scl_lo_o <= 1'b1;
   endtask : start

   // Stop: data rises while clock is high, clock then stands high
   task automatic stop;
      @(posedge clk_i);
      sda_lo_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      scl_lo_o <= 1'b0;
      repeat (4) @(posedge clk_i);
      sda_lo_o <= 1'b0;
      repeat (4) @(posedge clk_i);
   endtask : stop
endmodule : isa_master
`default_nettype wire

// *** bench/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_top
   import isa_pkg::*;
   ;
   // ****************************************
   // Signals
   // ****************************************
   logic              clk, rst_n, rd, wr, wait_r, irq, m_sel, q, msk;
   logic [ADDR_W-1:0] adr;
   logic [DATA_W-1:0] wdat, rdat;
   logic [7:0]        r, d1, d2;
   logic [6:0]        a;               // Own address under test
   int                mismatches, n_checks;
   isa_pins_t         o0, o1, oe0, oe1;
   wire isa_pins_t    p0, p1;
   wire logic         m_scl_lo, m_sda_lo, scl, sda;

   // Open-drain wires with pull-ups; master sits on one pair
   assign p0  = {oe0.scl & ~(m_scl_lo & ~m_sel),
                 oe0.sda & ~(m_sda_lo & ~m_sel)};
   assign p1  = {oe1.scl & ~(m_scl_lo & m_sel),
                 oe1.sda & ~(m_sda_lo & m_sel)};
   assign scl = m_sel ? p1.scl : p0.scl;
   assign sda = m_sel ? p1.sda : p0.sda;

   isa_slave dut_u (.clk_i(clk), .rst_n_i(rst_n), .avs_address_i(adr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wait_r), .irq_o(irq),
      .pair0_i(p0), .pair0_o(o0), .pair0_oe_n_o(oe0),
      .pair1_i(p1), .pair1_o(o1), .pair1_oe_n_o(oe1));
   isa_master mst_u (.clk_i(clk), .scl_i(scl), .sda_i(sda),
      .scl_lo_o(m_scl_lo), .sda_lo_o(m_sda_lo));

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [7:0] sla(input logic [6:0] x, input logic w);
      return {x, w};
   endfunction : sla

   // Byte seen after the slave let go: released line reads ones
   function automatic logic [7:0] tx_exp(input logic aa, input logic [7:0] d);
      return aa ? d : BYTE_IDLE;
   endfunction : tx_exp

   task automatic finish_test;
      if (mismatches == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : finish_test

   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      n_checks++;
      if (g !== e)
      begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // One Avalon cycle; request held until waitrequest is seen low
   task automatic bus(input logic w, input logic [7:0] i,
                      input logic [7:0] d);
      @(posedge clk);
      adr  <= {i, 2'b00};
      wr   <= w;
      rd   <= ~w;
      wdat <= {24'h0, d};
      // No cycle count assumed; only the watchdog ends a stuck wait
      do
         @(posedge clk);
      while (wait_r !== 1'b0);
      r = rdat[7:0];
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus

   // Software service of an event: check, read state, clear
   task automatic svc(input logic ev, input logic [7:0] c);
      repeat (8) @(posedge clk);
      bus(0, IDX_STAT, 0);
      chk("event", {7'h0, ev}, r & 8'h01);
      chk("irq", {7'h0, ev & msk}, {7'h0, irq});
      if (ev)
      begin
         bus(0, IDX_CODE, 0);
         chk("state", c, r);
         bus(1, IDX_STAT, 8'h01);
      end
   endtask : svc

   // Master sends a byte, software serves, master clocks the answer
   task automatic xfer(input logic [7:0] b, input logic ev,
                       input logic [7:0] c, input logic ea);
      for (int i = 7; i >= 0; i--)
         mst_u.bit_clk(b[i], q);
      bus(1, IDX_DATA, d1);
      svc(ev, c);
      mst_u.bit_clk(1'b1, q);
      chk("ack", {7'h0, ea}, {7'h0, q});
   endtask : xfer

   // Master reads a byte, then acknowledges (0) or not (1)
   task automatic rbyte(input logic [7:0] e, input logic ma);
      logic [7:0] v;
      for (int i = 7; i >= 0; i--)
         mst_u.bit_clk(1'b1, v[i]);
      chk("rx", e, v);
      mst_u.bit_clk(ma, q);
   endtask : rbyte

   // ****************************************
   // Clock, watchdog, tests
   // ****************************************
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Whole run takes about two thousand cycles; twenty times that means a hang
   initial
   begin
      repeat (40000) @(posedge clk);
      mismatches++;
      finish_test();
   end

   initial
   begin
      rst_n = 1'b0;
      rd = 1'b0;
      wr = 1'b0;
      adr = '0;
      wdat = '0;
      m_sel = 1'b0;
      msk = 1'b1;
      mismatches = 0;
      n_checks = 0;
      void'($urandom(32'hab55f9e7));
      a  = 7'(2 + $urandom % 126);
      d1 = 8'($urandom);
      d2 = 8'($urandom);
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      bus(0, IDX_OWN, 0);
      chk("own_rst", OWN_RST, r);
      bus(0, IDX_CODE, 0);
      chk("code_rst", CODE_IDLE, r);
      bus(0, 8'h10, 0);
      chk("unmapped", BYTE_ZERO, r);
      bus(1, IDX_MASK, 8'h01);
      bus(1, IDX_OWN, sla(a, 0));
      bus(0, IDX_OWN, 0);
      chk("own", sla(a, 0), r);
      bus(1, IDX_CTRL, 8'h44);
      // Write to own address, then one data byte
      mst_u.start();
      xfer(sla(a, 0), 1, CODE_SLA_W, 0);
      xfer(d2, 1, CODE_RX_ACK, 0);
      bus(0, IDX_DATA, 0);
      chk("rx_data", d2, r);
      // Neighbour address and general call while disabled
      mst_u.start();
      xfer(sla(a ^ 7'h01, 0), 0, 0, 1);
      mst_u.start();
      xfer(8'h00, 0, 0, 1);
      mst_u.stop();
      // General call accepted, with the interrupt masked
      bus(1, IDX_OWN, sla(a, 1));
      bus(1, IDX_MASK, 8'h00);
      msk = 1'b0;
      mst_u.start();
      xfer(8'h00, 1, CODE_GCALL, 0);
      mst_u.stop();
      bus(1, IDX_MASK, 8'h01);
      msk = 1'b1;
      // Acknowledge off: own address and general call ignored
      bus(1, IDX_CTRL, 8'h40);
      for (int k = 0; k < 2; k++)
      begin
         mst_u.start();
         xfer(k ? 8'h00 : sla(a, 0), 0, 0, 1);
         mst_u.stop();
      end
      // Withheld acknowledge drops the slave until addressed again
      bus(1, IDX_CTRL, 8'h44);
      mst_u.start();
      xfer(sla(a, 0), 1, CODE_SLA_W, 0);
      bus(1, IDX_CTRL, 8'h40);
      xfer(d1, 1, CODE_RX_NACK, 1);
      bus(1, IDX_CTRL, 8'h44);
      xfer(d2, 0, 0, 1);
      // Read, last byte with acknowledge off, then ones
      mst_u.start();
      xfer(sla(a, 1), 1, CODE_SLA_R, 0);
      rbyte(d1, 0);
      bus(1, IDX_DATA, d2);
      bus(1, IDX_CTRL, 8'h40);
      svc(1, CODE_TX_ACK);
      rbyte(d2, 0);
      svc(1, CODE_TX_LAST);
      rbyte(tx_exp(0, d2), 1);
      svc(0, 0);
      // Master refuses a byte: slave drops
      bus(1, IDX_CTRL, 8'h44);
      mst_u.start();
      xfer(sla(a, 1), 1, CODE_SLA_R, 0);
      rbyte(d1, 1);
      svc(1, CODE_TX_NACK);
      mst_u.stop();
      // Pair select: pair 1 chosen, traffic on pair 0 goes unseen
      bus(1, IDX_CTRL, 8'h45);
      mst_u.start();
      xfer(sla(a, 0), 0, 0, 1);
      mst_u.stop();
      m_sel <= 1'b1;
      mst_u.start();
      xfer(sla(a, 0), 1, CODE_SLA_W, 0);
      mst_u.stop();
      chk("pair_out", BYTE_ZERO, {4'h0, o1, o0});
      finish_test();
   end
endmodule : tb_top
`default_nettype wire

// *** hdl/isa_slave.sv ***
`timescale 1ns/1ns
`default_nettype none
// ************************************************************
// Two-wire slave: own address, acknowledge, pin pair routing
// ************************************************************
// Summary of operation
// R1: ack_enable set: drive ACK as receiver/addressed
// R2: ack_enable clear: NACK, ignore address, no address event
// R3: Missing ACK drops slave to not addressed
// R4: Last byte with ack_enable clear: C8H, FFH
// R5: Pair select routes SCL/SDA to pin pair
// R6: Routing follows select bit at once; the registered pin enables follow one clock later
// R7: Own address bits 7..1 used in slave mode
// R8: First byte after START matched against address
// R9: Software should program a nonzero own address
// R10: General call needs enable bit and ack_enable
// R11: Reportable state sets event flag, stretches SCL
module isa_slave
   import isa_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   // Avalon-MM slave
   input  wire logic [ADDR_W-1:0] avs_address_i,
   input  wire logic              avs_read_i,
   input  wire logic              avs_write_i,
   input  wire logic [DATA_W-1:0] avs_writedata_i,
   output var  logic [DATA_W-1:0] avs_readdata_o,
   output var  logic              avs_waitrequest_o,
   // Interrupt
   output var  logic              irq_o,
   // Pin pair 0 and pin pair 1, open drain, enable low drives
   input  wire isa_pins_t         pair0_i,
   output var  isa_pins_t         pair0_o,
   output var  isa_pins_t         pair0_oe_n_o,
   input  wire isa_pins_t         pair1_i,
   output var  isa_pins_t         pair1_o,
   output var  isa_pins_t         pair1_oe_n_o
);

   // ************************************************************
   // Declarations
   // ************************************************************
   logic [7:0]       ctrl;                    // Control register
   logic [7:0]       own;                     // own_slave_address
   logic [7:0]       tx_data;                 // Byte to send next
   logic [7:0]       rx_data;                 // Last byte received
   logic [7:0]       code;                    // bus_state_code
   logic [IRQ_W-1:0] stat;                    // Sticky events
   logic [IRQ_W-1:0] mask;                    // Interrupt mask
   logic [IRQ_W-1:0] ev_set;                  // Event pulses
   logic [3:0]       lines;                   // Filtered pin levels
   logic             scl, sda;                // Selected pair
   logic             scl_q, sda_q;            // Previous levels
   logic             rise, fall;              // SCL edges
   logic             start, stop;             // Bus conditions
   isa_state_t       st;                      // Sequencer state
   logic [3:0]       cnt;                     // Bit count in byte
   logic [7:0]       shift_in;                // Receive shifter
   logic [7:0]       tx_shift;                // Transmit shifter
   logic             tx_last;                 // Byte sent with ACK off
   logic             is_read;                 // Direction bit
   logic             ack_bit;                 // Our answer in ACK slot
   logic             m_ack;                   // Master answer
   logic             hit;                     // Address accepted
   logic             byte_end;                // Eighth bit finished
   logic             evt_set;                 // Reportable state
   logic [7:0]       evt_code;                // Its code
   logic             scl_drv, sda_drv;        // Lines pulled low
   logic             wr_en;                   // Write takes effect
   logic [7:0]       widx;                    // Word index

   wire logic sel    = ctrl[CTRL_SEL_BIT];
   wire logic ack_en = ctrl[CTRL_ACK_BIT];
   wire logic en     = ctrl[CTRL_EN_BIT];
   wire logic evt    = stat[STAT_EVT_BIT];

   // Word index from a byte address
   function automatic logic [7:0] word_idx(input logic [ADDR_W-1:0] a);
      return a[9:2];
   endfunction : word_idx

   // ************************************************************
   // Register bus
   // ************************************************************
   assign widx  = word_idx(avs_address_i);
   assign wr_en = avs_write_i && !avs_waitrequest_o;

   // One wait cycle: request seen, answer at the next edge
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         avs_waitrequest_o <= 1'b1;
      else
         avs_waitrequest_o <= !((avs_read_i || avs_write_i)
                                && avs_waitrequest_o);
   end

   // Read data captured in the wait cycle; unmapped reads zero
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         avs_readdata_o <= '0;
      else if (avs_read_i && avs_waitrequest_o)
      begin
         case (widx)
            IDX_CTRL: avs_readdata_o <= {24'h0, ctrl};
            IDX_OWN:  avs_readdata_o <= {24'h0, own};
            IDX_DATA: avs_readdata_o <= {24'h0, rx_data};
            IDX_CODE: avs_readdata_o <= {24'h0, code};
            IDX_STAT: avs_readdata_o <= {30'h0, stat};
            IDX_MASK: avs_readdata_o <= {30'h0, mask};
            default:  avs_readdata_o <= '0;
         endcase
      end
   end

   // Software registers; select takes effect the same edge
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         ctrl    <= CTRL_RST;
         own     <= OWN_RST;
         tx_data <= BYTE_IDLE;
         mask    <= '0;
      end
      else if (wr_en)
      begin
         case (widx)
            IDX_CTRL: ctrl    <= avs_writedata_i[7:0];  // see R6
            IDX_OWN:  own     <= avs_writedata_i[7:0];
            IDX_DATA: tx_data <= avs_writedata_i[7:0];
            IDX_MASK: mask    <= avs_writedata_i[IRQ_W-1:0];
            default:  ;                       // Unmapped: ignored
         endcase
      end
   end

   // Sticky events, write one to clear; a new event wins
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         stat <= '0;
      else if (wr_en && widx == IDX_STAT)
         stat <= (stat & ~avs_writedata_i[IRQ_W-1:0]) | ev_set;
      else
         stat <= stat | ev_set;
   end

   assign ev_set = {stop, evt_set};

   // Level interrupt while any unmasked event is pending
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         irq_o <= 1'b0;
      else
         irq_o <= |(stat & mask);
   end

   // ************************************************************
   // Pin sampling and bus conditions
   // ************************************************************
   isa_sync #(.W(4)) u_sync (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .async_i ({pair1_i.scl, pair1_i.sda, pair0_i.scl, pair0_i.sda}),
      .sync_o  (lines)
   );

   // Pair mux; a select change mid-frame may look like an edge
   assign scl = sel ? lines[3] : lines[1];    // see R5
   assign sda = sel ? lines[2] : lines[0];    // see R5

   // Previous levels for edge detection
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end
      else
      begin
         scl_q <= scl;
         sda_q <= sda;
      end
   end

   assign rise  = scl && !scl_q;
   assign fall  = !scl && scl_q;
   assign start = scl && scl_q && sda_q && !sda;
   assign stop  = en && scl && scl_q && !sda_q && sda;

   // ************************************************************
   // Byte decisions
   // ************************************************************
   assign byte_end = fall && cnt == BYTE_BITS;

   // Own address or general call, both only with ack_enable set
   always_comb
   begin
      hit = ack_en                                            // see R2
            && ((shift_in[7:1] == own[7:1]                    // see R7
                 && shift_in[7:1] != BYTE_ZERO[6:0])
                || (shift_in == BYTE_ZERO && own[OWN_GC_BIT])); // see R10
   end

   // Which reportable state is entered this cycle
   always_comb
   begin
      evt_set  = 1'b0;
      evt_code = code;
      if (en && !start && !stop)
      begin
         case (st)
            ST_ADDR:
               if (byte_end && hit)                           // see R8
               begin
                  evt_set  = 1'b1;
                  evt_code = shift_in == BYTE_ZERO ? CODE_GCALL
                           : shift_in[0] ? CODE_SLA_R : CODE_SLA_W;
               end
            ST_RX:
               if (byte_end)
               begin
                  evt_set  = 1'b1;
                  evt_code = ack_en ? CODE_RX_ACK : CODE_RX_NACK;
               end
            ST_ACK_IN:
               if (fall)
               begin
                  evt_set  = 1'b1;
                  evt_code = !m_ack ? CODE_TX_NACK
                           : tx_last ? CODE_TX_LAST : CODE_TX_ACK; // see R4
               end
            default: ;
         endcase
      end
   end

   // Reported code follows each event
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         code <= CODE_IDLE;
      else if (evt_set)
         code <= evt_code;                    // see R11
   end

   // Our acknowledge follows ack_enable until the event is cleared
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         ack_bit <= 1'b0;
      else if (evt)
         ack_bit <= ack_en;                   // see R1 R2
   end

   // ************************************************************
   // Slave sequencer
   // ************************************************************
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         st       <= ST_NOT_ADDR;
         cnt      <= '0;
         shift_in <= '0;
         rx_data  <= '0;
         is_read  <= 1'b0;
         m_ack    <= 1'b0;
      end
      else if (!en || stop)
         st <= ST_NOT_ADDR;
      else if (start)
      begin
         st  <= ST_ADDR;                      // see R8
         cnt <= '0;
      end
      else
      begin
         case (st)
            ST_ADDR, ST_RX:
            begin
               if (rise)
               begin
                  shift_in <= {shift_in[6:0], sda};
                  cnt      <= cnt + 4'h1;
               end
               if (byte_end)
               begin
                  if (st == ST_RX)
                     rx_data <= shift_in;
                  is_read <= (st == ST_ADDR) && shift_in[0];
                  // Unmatched address or no ACK: leave the frame
                  st <= (st == ST_RX || hit) ? ST_ACK_OUT
                                             : ST_NOT_ADDR; // see R2
               end
            end
            ST_ACK_OUT:
               if (fall)
               begin
                  cnt <= '0;
                  st  <= !ack_bit ? ST_NOT_ADDR          // see R3
                       : is_read ? ST_TX : ST_RX;
               end
            ST_TX:
               if (fall)
               begin
                  cnt <= cnt + 4'h1;
                  if (cnt == BYTE_BITS - 4'h1)
                     st <= ST_ACK_IN;
               end
            ST_ACK_IN:
            begin
               if (rise)
                  m_ack <= !sda;
               if (fall)
               begin
                  cnt <= '0;
                  st  <= (m_ack && !tx_last) ? ST_TX
                                             : ST_NOT_ADDR; // see R3 R4
               end
            end
            ST_NOT_ADDR: ;                    // Wait for a START
            default: st <= ST_NOT_ADDR;
         endcase
      end
   end

   // Transmit shifter: loaded as software releases the event
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         tx_shift <= BYTE_IDLE;
         tx_last  <= 1'b0;
      end
      else if (evt && !ev_set[STAT_EVT_BIT] && wr_en && widx == IDX_STAT
               && avs_writedata_i[STAT_EVT_BIT])
      begin
         tx_shift <= tx_data;
         tx_last  <= !ack_en;                 // see R4
      end
      else if (st == ST_TX && fall)
         tx_shift <= {tx_shift[6:0], 1'b1};
   end

   // ************************************************************
   // Line drive and routing
   // ************************************************************
   assign scl_drv = evt;                      // see R11
   assign sda_drv = (st == ST_ACK_OUT && !evt && ack_bit)     // see R1
                    || (st == ST_TX && !tx_shift[7]);

   // Only the pair selected at the previous edge is pulled low
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         pair0_o      <= '0;
         pair1_o      <= '0;
         pair0_oe_n_o <= '1;
         pair1_oe_n_o <= '1;
      end
      else
      begin
         pair0_o      <= '0;
         pair1_o      <= '0;
         pair0_oe_n_o <= '{scl: !(scl_drv && !sel),
                           sda: !(sda_drv && !sel)};          // see R5 R6
         pair1_oe_n_o <= '{scl: !(scl_drv && sel),
                           sda: !(sda_drv && sel)};           // see R5 R6
      end
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   AST_ACK_LOW: assert property ( // see R1
      st == ST_ACK_OUT && !evt && ack_bit
      |=> (sel ? pair1_oe_n_o.sda : pair0_oe_n_o.sda) == 1'b0
          || $changed(sel))
      else $error("ACK not driven low");

   AST_NO_EVT_AA0: assert property ( // see R2
      st == ST_ADDR && byte_end && !ack_en && !start && !stop
      |=> !evt && st == ST_NOT_ADDR)
      else $error("Address taken with ack_enable clear");

   AST_NACK_DROP: assert property ( // see R3
      st == ST_ACK_OUT && fall && !ack_bit && en && !start && !stop
      |=> st == ST_NOT_ADDR)
      else $error("Slave stayed addressed after NACK");

   AST_LAST_BYTE: assert property ( // see R4
      evt_set && evt_code == CODE_TX_LAST
      |=> st == ST_NOT_ADDR && code == CODE_TX_LAST ##1
          pair0_oe_n_o.sda && pair1_oe_n_o.sda)
      else $error("Last byte did not end the transfer");

   AST_ROUTE: assert property ( // see R5 R6
      $past(sel) ? (pair0_oe_n_o == '1) : (pair1_oe_n_o == '1))
      else $error("Unselected pair driven");

   AST_GC: assert property ( // see R10
      evt_set && evt_code == CODE_GCALL |-> own[OWN_GC_BIT] && ack_en)
      else $error("General call taken while disabled");

   AST_OWN_MATCH: assert property ( // see R7 R8
      evt_set && (evt_code == CODE_SLA_W || evt_code == CODE_SLA_R)
      |-> shift_in[7:1] == own[7:1])
      else $error("Foreign address accepted");

   AST_STRETCH: assert property ( // see R11
      evt_set |=> evt ##1
      (sel ? pair1_oe_n_o.scl : pair0_oe_n_o.scl) == 1'b0 || $changed(sel))
      else $error("SCL not held during event");

   AST_WAIT: assert property (
      (avs_read_i || avs_write_i) && avs_waitrequest_o
      |=> !avs_waitrequest_o)
      else $error("Bus answer late");

   COV_WRITE: cover property (evt_set && evt_code == CODE_RX_ACK);
   COV_READ:  cover property (evt_set && evt_code == CODE_TX_ACK);
   COV_LAST:  cover property (evt_set && evt_code == CODE_TX_LAST);
   COV_GCALL: cover property (evt_set && evt_code == CODE_GCALL);

endmodule : isa_slave
`default_nettype wire

// *** hdl/isa_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
// ************************************************************
// Three-stage input synchroniser with agreement filter
// ************************************************************
module isa_sync #(
   parameter int W = 4                        // Number of lines
) (
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  wire logic [W-1:0] async_i,         // Lines from pins
   output var  logic [W-1:0] sync_o           // Filtered levels
);

   logic [W-1:0] meta;                        // First stage, only read below
   logic [W-1:0] stage2;                      // Second stage
   logic [W-1:0] stage3;                      // Third stage

   // Chain; a change is taken once stages two and three agree
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         meta   <= '1;
         stage2 <= '1;
         stage3 <= '1;
         sync_o <= '1;                        // Idle bus is high
      end
      else
      begin
         meta   <= async_i;
         stage2 <= meta;
         stage3 <= stage2;
         for (int i = 0; i < W; i++)
         begin
            if (stage2[i] == stage3[i])
               sync_o[i] <= stage3[i];
         end
      end
   end

endmodule : isa_sync
`default_nettype wire

// *** shared/isa_pkg.sv ***
// ************************************************************
// Constants and types of the slave address and acknowledge block
// ************************************************************
package isa_pkg;

   // Bus geometry
   localparam int ADDR_W = 10;                // Avalon byte address
   localparam int DATA_W = 32;                // Avalon data width

   // Register indices, byte address is four times the index
   localparam logic [7:0] IDX_CTRL = 8'hc0;   // Control bits
   localparam logic [7:0] IDX_OWN  = 8'hc1;   // own_slave_address
   localparam logic [7:0] IDX_DATA = 8'hd0;   // Data to send / received
   localparam logic [7:0] IDX_CODE = 8'hd1;   // bus_state_code
   localparam logic [7:0] IDX_STAT = 8'hd2;   // Sticky event bits
   localparam logic [7:0] IDX_MASK = 8'hd3;   // Interrupt mask

   // Field positions
   localparam int CTRL_SEL_BIT  = 0;          // bus_pin_pair_select
   localparam int CTRL_ACK_BIT  = 2;          // ack_enable
   localparam int CTRL_EN_BIT   = 6;          // Block enable
   localparam int OWN_GC_BIT    = 0;          // general_call_enable
   localparam int STAT_EVT_BIT  = 0;          // Transfer event flag
   localparam int STAT_STOP_BIT = 1;          // STOP seen
   localparam int IRQ_W         = 2;          // Number of event bits

   // Reset values and fill patterns
   localparam logic [7:0] CTRL_RST  = 8'h00;
   localparam logic [7:0] OWN_RST   = 8'h00;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] BYTE_IDLE = 8'hff;  // Released line reads ones
   localparam logic [3:0] BYTE_BITS = 4'h8;   // Bits in one byte

   // Reported bus states
   localparam logic [7:0] CODE_IDLE    = 8'hf8;
   localparam logic [7:0] CODE_SLA_W   = 8'h60;
   localparam logic [7:0] CODE_GCALL   = 8'h70;
   localparam logic [7:0] CODE_RX_ACK  = 8'h80;
   localparam logic [7:0] CODE_RX_NACK = 8'h88;
   localparam logic [7:0] CODE_SLA_R   = 8'ha8;
   localparam logic [7:0] CODE_TX_ACK  = 8'hb8;
   localparam logic [7:0] CODE_TX_NACK = 8'hc0;
   localparam logic [7:0] CODE_TX_LAST = 8'hc8;

   // One pin pair of the two-wire bus
   typedef struct packed {
      logic scl;
      logic sda;
   } isa_pins_t;

   // Slave sequencer states
   typedef enum logic [2:0] {
      ST_NOT_ADDR,
      ST_ADDR,
      ST_ACK_OUT,
      ST_RX,
      ST_TX,
      ST_ACK_IN
   } isa_state_t;

endpackage : isa_pkg
